/* File: verilog/config_fuse_and_code_protect.sv */
// configuration byte bank with decoded settings and code protection
`timescale 1ns/1ps
module config_fuse_and_code_protect
    import cfg_fuse_pkg::*;
#(
    parameter logic [15:0] DEVICE_ID = 16'h1234  // arbitrary value
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // nonvolatile image and storage update
    input wire cfg_image_type i_nv_image,
    output logic o_nv_wr,
    output logic [2:0] o_nv_index,
    output logic [7:0] o_nv_wdata,
    // core table access
    input wire access_type i_tbl,
    input wire logic [21:0] i_tbl_pc,
    output logic [7:0] o_tbl_rdata,
    output logic o_tbl_rvalid,
    output logic o_tbl_wr_blocked,
    // external programmer
    input wire access_type i_prg,
    input wire logic i_prg_eeprom,
    input wire logic i_prg_erase_chip,
    input wire logic i_prg_erase_block,
    input wire logic [2:0] i_prg_erase_sel,
    output logic [7:0] o_prg_rdata,
    output logic o_prg_rvalid,
    output logic o_prg_denied,
    // program memory and eeprom
    input wire logic [7:0] i_pm_rdata,
    input wire logic [7:0] i_ee_rdata,
    output logic o_pm_wr,
    output logic o_ee_wr,
    output logic [21:0] o_mem_addr,
    output logic [7:0] o_mem_wdata,
    output logic o_erase_chip,
    output logic o_erase_block,
    output logic [2:0] o_erase_sel,
    // chip-level controls
    input wire logic i_software_watchdog_enable_bit,
    input wire logic i_shared_reset_input_pin_n,
    input wire logic i_stack_fault,
    output settings_type o_settings,
    output logic o_config_valid,
    output logic o_master_reset_input,
    output logic o_shared_pin_data,
    output logic o_stack_fault_reset
);
    // ==========================================================
    // helpers
    function automatic logic [3:0] cfg_decode(input logic [21:0] a);
        logic [3:0] r;
        r = 4'h0;
        unique case (a)
            ADDR_WDT: r = {1'b1, IDX_WDT};
            ADDR_PIN: r = {1'b1, IDX_PIN};
            ADDR_DBG: r = {1'b1, IDX_DBG};
            ADDR_CP: r = {1'b1, IDX_CP};
            ADDR_CPB: r = {1'b1, IDX_CPB};
            ADDR_WRT: r = {1'b1, IDX_WRT};
            ADDR_EBTR: r = {1'b1, IDX_EBTR};
            default: r = 4'h0;
        endcase
        return r;
    endfunction

    function automatic logic [7:0] cfg_mask(input logic [2:0] i);
        logic [7:0] m;
        m = 8'h00;
        unique case (i)
            IDX_WDT: m = MASK_WDT;
            IDX_PIN: m = MASK_PIN;
            IDX_DBG: m = MASK_DBG;
            IDX_CP: m = MASK_CP;
            IDX_CPB: m = MASK_CPB;
            IDX_WRT: m = MASK_WRT;
            IDX_EBTR: m = MASK_EBTR;
            default: m = 8'h00;
        endcase
        return m;
    endfunction

    function automatic logic [7:0] cfg_blank(input logic [2:0] i);
        logic [7:0] b;
        b = 8'h00;
        unique case (i)
            IDX_WDT: b = BLANK_WDT;
            IDX_PIN: b = BLANK_PIN;
            IDX_DBG: b = BLANK_DBG;
            IDX_CP: b = BLANK_CP;
            IDX_CPB: b = BLANK_CPB;
            IDX_WRT: b = BLANK_WRT;
            IDX_EBTR: b = BLANK_EBTR;
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    // bit of a protection byte that guards a region
    function automatic int region_bit(input logic [2:0] reg_n);
        return (reg_n == REGION_BOOT) ? BIT_BOOT : int'(reg_n);
    endfunction

    // config, device id or nothing, for either access path
    function automatic logic [8:0] space_read(input logic [21:0] a,
                                              input logic [7:0] b,
                                              input logic [2:0] i);
        logic [3:0] d;
        logic [8:0] r;
        d = cfg_decode(a);
        r = 9'h000;
        if (d[3]) begin
            r = {1'b1, b & cfg_mask(i)};
        end else if (a == ADDR_DEVID_LO) begin
            r = {1'b1, DEVICE_ID[7:0]};
        end else if (a == ADDR_DEVID_HI) begin
            r = {1'b1, DEVICE_ID[15:8]};
        end
        return r;
    endfunction

    // ==========================================================
    // state
    state_type state, next_state;
    logic [7:0] cfg [CFG_N];
    logic [7:0] next_cfg [CFG_N];
    logic [2:0] tbl_region, pc_region, prg_region;
    logic reset_pin_level;
    logic [3:0] tbl_dec, prg_dec;
    logic [7:0] tbl_byte, prg_byte;
    logic [8:0] tbl_space, prg_space;
    settings_type next_settings;
    logic next_valid, next_tbl_rvalid, next_tbl_wr_blocked;
    logic next_prg_rvalid, next_prg_denied, next_pm_wr, next_ee_wr;
    logic next_nv_wr, next_erase_chip, next_erase_block;
    logic next_master_reset, next_shared_pin, next_stack_reset;
    logic [7:0] next_tbl_rdata, next_prg_rdata, next_nv_wdata;
    logic [7:0] next_mem_wdata;
    logic [2:0] next_nv_index, next_erase_sel;
    logic [21:0] next_mem_addr;

    pm_region_decode tbl_dec_u (.i_addr(i_tbl.addr), .o_region(tbl_region));
    pm_region_decode pc_dec_u (.i_addr(i_tbl_pc), .o_region(pc_region));
    pm_region_decode prg_dec_u (.i_addr(i_prg.addr), .o_region(prg_region));
    level_sync pin_sync_u (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_async(i_shared_reset_input_pin_n),
        .o_sync(reset_pin_level)
    );

    assign tbl_dec = cfg_decode(i_tbl.addr);
    assign prg_dec = cfg_decode(i_prg.addr);
    assign tbl_byte = cfg[tbl_dec[2:0]];
    assign prg_byte = cfg[prg_dec[2:0]];
    assign tbl_space = space_read(i_tbl.addr, tbl_byte, tbl_dec[2:0]);
    assign prg_space = space_read(i_prg.addr, prg_byte, prg_dec[2:0]);

    // ==========================================================
    // bank and access paths
    always_comb begin
        next_state = state;
        next_cfg = cfg;
        next_tbl_rvalid = 1'b0;
        next_tbl_rdata = o_tbl_rdata;
        next_tbl_wr_blocked = 1'b0;
        next_prg_rvalid = 1'b0;
        next_prg_rdata = o_prg_rdata;
        next_prg_denied = 1'b0;
        next_pm_wr = 1'b0;
        next_ee_wr = 1'b0;
        next_mem_addr = o_mem_addr;
        next_mem_wdata = o_mem_wdata;
        next_nv_wr = 1'b0;
        next_nv_index = o_nv_index;
        next_nv_wdata = o_nv_wdata;
        next_erase_chip = 1'b0;
        next_erase_block = 1'b0;
        next_erase_sel = o_erase_sel;
        unique case (state)
            ST_LOAD: begin
                for (int i = 0; i < CFG_N; i++) begin
                    next_cfg[i] = i_nv_image[i] & cfg_mask(3'(i));
                end
                next_state = ST_RUN;
            end
            ST_RUN: begin
                // programmer has priority; a core access in the same
                // cycle is dropped, the core gets no answer for it
                if (i_prg_erase_chip) begin
                    for (int i = 0; i < CFG_N; i++) begin
                        next_cfg[i] = cfg_blank(3'(i));
                    end
                    next_erase_chip = 1'b1;
                end else if (i_prg_erase_block) begin
                    next_erase_block = 1'b1;
                    next_erase_sel = i_prg_erase_sel;
                    if (i_prg_erase_sel == REGION_BOOT) begin
                        next_cfg[IDX_CPB][BIT_BOOT] = 1'b1;
                    end else begin
                        next_cfg[IDX_CP][region_bit(i_prg_erase_sel)] = 1'b1;
                    end
                    next_cfg[IDX_WRT][region_bit(i_prg_erase_sel)] = 1'b1;
                    next_cfg[IDX_EBTR][region_bit(i_prg_erase_sel)] = 1'b1;
                end else if (i_prg.rd) begin
                    next_prg_rvalid = 1'b1;
                    if (i_prg_eeprom) begin
                        next_prg_denied = ~cfg[IDX_CPB][BIT_CPD];
                        next_prg_rdata = next_prg_denied ? 8'h00 : i_ee_rdata;
                    end else if (prg_space[8]) begin
                        next_prg_rdata = prg_space[7:0];
                    end else if (prg_region == REGION_BOOT) begin
                        next_prg_denied = ~cfg[IDX_CPB][BIT_BOOT];
                        next_prg_rdata = next_prg_denied ? 8'h00 : i_pm_rdata;
                    end else if (prg_region != REGION_NONE) begin
                        next_prg_denied =
                            ~cfg[IDX_CP][region_bit(prg_region)];
                        next_prg_rdata = next_prg_denied ? 8'h00 : i_pm_rdata;
                    end else begin
                        next_prg_rdata = i_pm_rdata;
                    end
                end else if (i_prg.wr) begin
                    next_mem_addr = i_prg.addr;
                    next_mem_wdata = i_prg.wdata;
                    if (i_prg_eeprom) begin
                        next_ee_wr = cfg[IDX_CPB][BIT_CPD];
                        next_prg_denied = ~cfg[IDX_CPB][BIT_CPD];
                    end else if (prg_dec[3]) begin
                        if (prg_dec[2:0] == IDX_CP || prg_dec[2:0] == IDX_CPB)
                        begin
                            next_cfg[prg_dec[2:0]] =
                                prg_byte & i_prg.wdata;
                        end else begin
                            next_cfg[prg_dec[2:0]] =
                                i_prg.wdata & cfg_mask(prg_dec[2:0]);
                        end
                        next_nv_wr = 1'b1;
                        next_nv_index = prg_dec[2:0];
                        next_nv_wdata = next_cfg[prg_dec[2:0]];
                    end else if (prg_region == REGION_BOOT) begin
                        next_pm_wr = cfg[IDX_CPB][BIT_BOOT];
                        next_prg_denied = ~cfg[IDX_CPB][BIT_BOOT];
                    end else if (prg_region != REGION_NONE) begin
                        next_pm_wr = cfg[IDX_CP][region_bit(prg_region)];
                        next_prg_denied = ~next_pm_wr;
                    end
                end else if (i_tbl.rd) begin
                    // code protect bits are not consulted here
                    next_tbl_rvalid = 1'b1;
                    if (tbl_space[8]) begin
                        next_tbl_rdata = tbl_space[7:0];
                    end else if (tbl_region != REGION_NONE &&
                                 !cfg[IDX_EBTR][region_bit(tbl_region)] &&
                                 pc_region != tbl_region) begin
                        next_tbl_rdata = 8'h00;
                    end else begin
                        next_tbl_rdata = i_pm_rdata;
                    end
                end else if (i_tbl.wr) begin
                    next_mem_addr = i_tbl.addr;
                    next_mem_wdata = i_tbl.wdata;
                    if (tbl_dec[3]) begin
                        if (tbl_dec[2:0] == IDX_CP || tbl_dec[2:0] == IDX_CPB)
                        begin
                            next_cfg[tbl_dec[2:0]] =
                                tbl_byte & i_tbl.wdata;
                        end else begin
                            next_cfg[tbl_dec[2:0]] =
                                i_tbl.wdata & cfg_mask(tbl_dec[2:0]);
                        end
                        next_nv_wr = 1'b1;
                        next_nv_index = tbl_dec[2:0];
                        next_nv_wdata = next_cfg[tbl_dec[2:0]];
                    end else if (tbl_region != REGION_NONE &&
                                 !cfg[IDX_WRT][region_bit(tbl_region)]) begin
                        next_tbl_wr_blocked = 1'b1;
                    end else begin
                        next_pm_wr = 1'b1;
                    end
                end
            end
        endcase
    end

    // ==========================================================
    // decoded settings, taken from the live bank
    always_comb begin
        next_valid = (state == ST_RUN);
        next_settings.port_analog_config_field =
            cfg[IDX_PIN][BIT_PORT_ANALOG_AT_RESET_BIT] ? PORT_ANALOG_CONFIG_FIELD_ANALOG : PORT_ANALOG_CONFIG_FIELD_DIGITAL;
        next_settings.watchdog_ratio = WDT_RATIO_ONE
            << cfg[IDX_WDT][WDT_PS_LSB +: WDT_PS_W];
        next_settings.watchdog_run = cfg[IDX_WDT][BIT_WDT_FORCE] |
            i_software_watchdog_enable_bit;
        next_settings.reset_pin_select = cfg[IDX_PIN][BIT_RST_SEL];
        next_settings.low_power_timer_osc =
            cfg[IDX_PIN][BIT_LP_OSC];
        next_settings.ccp_on_port_c_pin_one =
            cfg[IDX_PIN][BIT_CCP_MX];
        next_settings.debugger_enable = ~cfg[IDX_DBG][BIT_DEBUG];
        next_settings.extended_instruction =
            cfg[IDX_DBG][BIT_EXTENDED_INSTRUCTION_BIT];
        next_settings.single_supply_program =
            cfg[IDX_DBG][BIT_LVP];
        next_settings.stack_fault_reset_en = cfg[IDX_DBG][BIT_STACK_FAULT_RESET_BIT];
        next_settings.eeprom_protected = ~cfg[IDX_CPB][BIT_CPD];
        next_settings.boot_protected = ~cfg[IDX_CPB][BIT_BOOT];
        // pin ignored as reset unless selected; active low at the pin
        next_master_reset = next_valid & cfg[IDX_PIN][BIT_RST_SEL] &
            ~reset_pin_level;
        next_shared_pin = ~cfg[IDX_PIN][BIT_RST_SEL] &
            reset_pin_level;
        next_stack_reset = next_valid & i_stack_fault &
            cfg[IDX_DBG][BIT_STACK_FAULT_RESET_BIT];
    end

    // ==========================================================
    // registers
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_LOAD;
            for (int i = 0; i < CFG_N; i++) begin
                cfg[i] <= 8'h00;
            end
            o_settings <= '0;
            o_config_valid <= 1'b0;
            o_tbl_rdata <= 8'h00;
            o_tbl_rvalid <= 1'b0;
            o_tbl_wr_blocked <= 1'b0;
            o_prg_rdata <= 8'h00;
            o_prg_rvalid <= 1'b0;
            o_prg_denied <= 1'b0;
            o_pm_wr <= 1'b0;
            o_ee_wr <= 1'b0;
            o_mem_addr <= '0;
            o_mem_wdata <= 8'h00;
            o_nv_wr <= 1'b0;
            o_nv_index <= 3'h0;
            o_nv_wdata <= 8'h00;
            o_erase_chip <= 1'b0;
            o_erase_block <= 1'b0;
            o_erase_sel <= 3'h0;
            o_master_reset_input <= 1'b0;
            o_shared_pin_data <= 1'b0;
            o_stack_fault_reset <= 1'b0;
        end else begin
            state <= next_state;
            cfg <= next_cfg;
            o_settings <= next_settings;
            o_config_valid <= next_valid;
            o_tbl_rdata <= next_tbl_rdata;
            o_tbl_rvalid <= next_tbl_rvalid;
            o_tbl_wr_blocked <= next_tbl_wr_blocked;
            o_prg_rdata <= next_prg_rdata;
            o_prg_rvalid <= next_prg_rvalid;
            o_prg_denied <= next_prg_denied;
            o_pm_wr <= next_pm_wr;
            o_ee_wr <= next_ee_wr;
            o_mem_addr <= next_mem_addr;
            o_mem_wdata <= next_mem_wdata;
            o_nv_wr <= next_nv_wr;
            o_nv_index <= next_nv_index;
            o_nv_wdata <= next_nv_wdata;
            o_erase_chip <= next_erase_chip;
            o_erase_block <= next_erase_block;
            o_erase_sel <= next_erase_sel;
            o_master_reset_input <= next_master_reset;
            o_shared_pin_data <= next_shared_pin;
            o_stack_fault_reset <= next_stack_reset;
        end
    end
endmodule

/* File: verilog/cfg_fuse_pkg.sv */
// constants, types and field layout of the configuration byte bank
package cfg_fuse_pkg;

    // ==========================================================
    // address space
    localparam int ADDR_W = 22;
    localparam logic [21:0] ADDR_WDT = 22'h300003;
    localparam logic [21:0] ADDR_PIN = 22'h300005;
    localparam logic [21:0] ADDR_DBG = 22'h300006;
    localparam logic [21:0] ADDR_CP = 22'h300008;
    localparam logic [21:0] ADDR_CPB = 22'h300009;
    localparam logic [21:0] ADDR_WRT = 22'h30000a;
    localparam logic [21:0] ADDR_EBTR = 22'h30000c;
    localparam logic [21:0] ADDR_DEVID_LO = 22'h3ffffe;
    localparam logic [21:0] ADDR_DEVID_HI = 22'h3fffff;

    // ==========================================================
    // byte indices inside the bank
    localparam int CFG_N = 7;
    localparam logic [2:0] IDX_WDT = 3'h0;
    localparam logic [2:0] IDX_PIN = 3'h1;
    localparam logic [2:0] IDX_DBG = 3'h2;
    localparam logic [2:0] IDX_CP = 3'h3;
    localparam logic [2:0] IDX_CPB = 3'h4;
    localparam logic [2:0] IDX_WRT = 3'h5;
    localparam logic [2:0] IDX_EBTR = 3'h6;

    // ==========================================================
    // implemented bits and unprogrammed values
    localparam logic [7:0] MASK_WDT = 8'h1f;
    localparam logic [7:0] MASK_PIN = 8'h87;
    localparam logic [7:0] MASK_DBG = 8'hc5;
    localparam logic [7:0] MASK_CP = 8'h0f;
    localparam logic [7:0] MASK_CPB = 8'hc0;
    localparam logic [7:0] MASK_WRT = 8'h4f;
    localparam logic [7:0] MASK_EBTR = 8'h4f;
    localparam logic [7:0] BLANK_WDT = 8'h1f;
    localparam logic [7:0] BLANK_PIN = 8'h83;
    localparam logic [7:0] BLANK_DBG = 8'h85;
    localparam logic [7:0] BLANK_CP = 8'h0f;
    localparam logic [7:0] BLANK_CPB = 8'hc0;
    localparam logic [7:0] BLANK_WRT = 8'h4f;
    localparam logic [7:0] BLANK_EBTR = 8'h4f;

    // ==========================================================
    // field positions
    localparam int BIT_WDT_FORCE = 0;
    localparam int WDT_PS_LSB = 1;
    localparam int WDT_PS_W = 4;
    localparam int WDT_RATIO_W = 16;
    localparam int BIT_RST_SEL = 7;
    localparam int BIT_LP_OSC = 2;
    localparam int BIT_PORT_ANALOG_AT_RESET_BIT = 1;
    localparam int BIT_CCP_MX = 0;
    localparam int BIT_DEBUG = 7;
    localparam int BIT_EXTENDED_INSTRUCTION_BIT = 6;
    localparam int BIT_LVP = 2;
    localparam int BIT_STACK_FAULT_RESET_BIT = 0;
    localparam int BIT_CPD = 7;
    localparam int BIT_BOOT = 6;
    localparam logic [2:0] PORT_ANALOG_CONFIG_FIELD_ANALOG = 3'h0;
    localparam logic [2:0] PORT_ANALOG_CONFIG_FIELD_DIGITAL = 3'h7;
    localparam logic [15:0] WDT_RATIO_ONE = 16'h0001;

    // ==========================================================
    // program memory regions
    localparam logic [21:0] BOOT_END = 22'h0007ff;
    localparam logic [21:0] PM_END = 22'h007fff;
    localparam int BLOCK_SHIFT = 13;
    localparam logic [2:0] REGION_BOOT = 3'h4;
    localparam logic [2:0] REGION_NONE = 3'h7;

    typedef logic [CFG_N-1:0][7:0] cfg_image_type;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b01,
        ST_RUN = 2'b10
    } state_type;

    typedef struct packed {
        logic [2:0] port_analog_config_field;
        logic [15:0] watchdog_ratio;
        logic watchdog_run;
        logic reset_pin_select;
        logic low_power_timer_osc;
        logic ccp_on_port_c_pin_one;
        logic debugger_enable;
        logic extended_instruction;
        logic single_supply_program;
        logic stack_fault_reset_en;
        logic eeprom_protected;
        logic boot_protected;
    } settings_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [21:0] addr;
        logic [7:0] wdata;
    } access_type;

endpackage

/* File: verilog/level_sync.sv */
// two flip-flop synchroniser for a pin level
`timescale 1ns/1ps
module level_sync (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // level in and out
    input wire logic i_async,
    output logic o_sync
);
    logic stage_one;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            stage_one <= 1'b1;
            o_sync <= 1'b1;
        end else begin
            stage_one <= i_async;
            o_sync <= stage_one;
        end
    end
endmodule

/* File: verilog/pm_region_decode.sv */
// maps a program address onto its protection region
`timescale 1ns/1ps
module pm_region_decode
    import cfg_fuse_pkg::*;
(
    input wire logic [21:0] i_addr,
    output logic [2:0] o_region
);
    always_comb begin
        if (i_addr <= BOOT_END) begin
            o_region = REGION_BOOT;
        end else if (i_addr <= PM_END) begin
            o_region = 3'(i_addr >> BLOCK_SHIFT);
        end else begin
            o_region = REGION_NONE;
        end
    end
endmodule

/* File: dv/cfg_fuse_props.sv */
// assertions on the configuration byte bank ports
`timescale 1ns/1ps
module cfg_fuse_props
    import cfg_fuse_pkg::*;
(
    // clock, reset and requests
    input wire logic i_sys_clk, i_rst,
    input wire cfg_image_type i_nv_image,
    input wire access_type i_tbl, i_prg,
    input wire logic i_prg_erase_chip, i_prg_erase_block,
    input wire logic i_software_watchdog_enable_bit, i_stack_fault,
    // answers and settings
    input wire logic o_tbl_rvalid, o_tbl_wr_blocked, o_prg_denied,
    input wire logic o_pm_wr, o_ee_wr, o_erase_block,
    input wire settings_type o_settings,
    input wire logic o_config_valid, o_stack_fault_reset
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // ==========================================================
    // table path, settings, protection
    a_tbl_rd_answer: assert property (
        o_config_valid && i_tbl.rd && !i_prg.rd && !i_prg.wr &&
        !i_prg_erase_chip && !i_prg_erase_block |=> o_tbl_rvalid)
        else $error("table read not answered");
    a_wdt_sw_run: assert property (
        o_config_valid && i_software_watchdog_enable_bit
        |=> o_settings.watchdog_run) else $error("watchdog not running");
    a_stack_reset_follow: assert property (
        o_config_valid && i_stack_fault |=>
        o_stack_fault_reset == o_settings.stack_fault_reset_en)
        else $error("stack reset");
    a_ratio_power_two: assert property (
        o_config_valid |-> $onehot(o_settings.watchdog_ratio))
        else $error("watchdog ratio not a power of two");
    a_blocked_no_write: assert property (
        o_tbl_wr_blocked |-> !o_pm_wr) else $error("blocked write went out");
    a_denied_no_write: assert property (
        o_prg_denied |-> !o_pm_wr && !o_ee_wr)
        else $error("denied access wrote memory");
    a_erase_from_prog: assert property (
        o_erase_block |-> $past(i_prg_erase_block))
        else $error("erase without programmer request");
    a_port_analog_config_field_at_load: assert property (
        $rose(o_config_valid) |-> o_settings.port_analog_config_field ==
        (i_nv_image[IDX_PIN][BIT_PORT_ANALOG_AT_RESET_BIT] ? PORT_ANALOG_CONFIG_FIELD_ANALOG : PORT_ANALOG_CONFIG_FIELD_DIGITAL))
        else $error("analog field wrong at load");
endmodule
bind config_fuse_and_code_protect cfg_fuse_props props (.i_sys_clk, .i_rst,
    .i_nv_image, .i_tbl, .i_prg, .i_prg_erase_chip, .i_prg_erase_block,
    .i_software_watchdog_enable_bit, .i_stack_fault, .o_tbl_rvalid,
    .o_tbl_wr_blocked, .o_prg_denied, .o_pm_wr, .o_ee_wr, .o_erase_block,
    .o_settings, .o_config_valid, .o_stack_fault_reset);

/* File: dv/mem_model.sv */
// program memory and data eeprom read model
`timescale 1ns/1ps
module mem_model #(
    parameter logic [7:0] PM_BYTE = 8'h5a,
    parameter logic [7:0] EE_BYTE = 8'h3c
) (
    // read data
    output logic [7:0] o_pm_rdata,
    output logic [7:0] o_ee_rdata
);
    // ==========================================================
    // fixed contents keep expectations free of address
    assign o_pm_rdata = PM_BYTE;
    assign o_ee_rdata = EE_BYTE;
endmodule

/* File: dv/testbench.sv */
// self-checking bench for the configuration byte bank
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin num_errors++; \
    $display("Error %s exp %h got %h", n, e, s); end end
module testbench
    import cfg_fuse_pkg::*;
;
    // ==========================================================
    // signals
    logic i_sys_clk = 1'b0, i_rst = 1'b1, i_prg_eeprom = 1'b0;
    logic i_prg_erase_chip = 1'b0, i_prg_erase_block = 1'b0;
    logic i_software_watchdog_enable_bit = 1'b0, i_stack_fault = 1'b0;
    logic i_shared_reset_input_pin_n = 1'b1;
    logic [2:0] i_prg_erase_sel = 3'h0, o_nv_index, o_erase_sel;
    logic [21:0] i_tbl_pc = 22'h000100, o_mem_addr;
    logic [7:0] i_pm_rdata, i_ee_rdata, o_nv_wdata, o_tbl_rdata;
    logic [7:0] o_prg_rdata, o_mem_wdata;
    logic o_nv_wr, o_tbl_rvalid, o_tbl_wr_blocked, o_prg_rvalid, o_pm_wr;
    logic o_prg_denied, o_ee_wr, o_erase_chip, o_erase_block;
    logic o_config_valid, o_master_reset_input, o_shared_pin_data;
    logic o_stack_fault_reset;
    // block 3 code-protect bit stays set
    cfg_image_type i_nv_image = {8'h4b, 8'h4d, 8'h40, 8'h0e, 8'h45, 8'h83,
        8'h08};
    access_type i_tbl = '0, i_prg = '0;
    settings_type o_settings;
    int num_errors = 0, checks = 0;
    mem_model model (.o_pm_rdata(i_pm_rdata), .o_ee_rdata(i_ee_rdata));
    // id value is arbitrary
    config_fuse_and_code_protect #(.DEVICE_ID(16'h5a3c)) dut (.i_sys_clk,
        .i_rst, .i_nv_image, .o_nv_wr, .o_nv_index, .o_nv_wdata, .i_tbl,
        .i_tbl_pc, .o_tbl_rdata, .o_tbl_rvalid, .o_tbl_wr_blocked, .i_prg,
        .i_prg_eeprom, .i_prg_erase_chip, .i_prg_erase_block,
        .i_prg_erase_sel, .o_prg_rdata, .o_prg_rvalid, .o_prg_denied,
        .i_pm_rdata, .i_ee_rdata, .o_pm_wr, .o_ee_wr, .o_mem_addr,
        .o_mem_wdata, .o_erase_chip, .o_erase_block, .o_erase_sel,
        .i_software_watchdog_enable_bit, .i_shared_reset_input_pin_n,
        .i_stack_fault, .o_settings, .o_config_valid, .o_master_reset_input,
        .o_shared_pin_data, .o_stack_fault_reset);
    always #4 i_sys_clk = ~i_sys_clk;
    // ==========================================================
    // access tasks: one-cycle request, answer seen next cycle
    task automatic acc(input bit p, r, w, input logic [21:0] a,
        input logic [7:0] d);
        @(negedge i_sys_clk);
        if (p) i_prg = '{r, w, a, d};
        else i_tbl = '{r, w, a, d};
        @(negedge i_sys_clk);
        i_prg = '0;
        i_tbl = '0;
    endtask
    task automatic rdchk(input bit p, input logic [21:0] a,
        input logic [7:0] e);
        acc(p, 1'b1, 1'b0, a, 8'h00);
        `CHK("rdata", {1'b1, e}, p ? {o_prg_rvalid, o_prg_rdata} :
            {o_tbl_rvalid, o_tbl_rdata})
    endtask
    task automatic erase(input bit chip);
        @(negedge i_sys_clk);
        i_prg_erase_chip = chip;
        i_prg_erase_block = !chip;
        @(negedge i_sys_clk);
        i_prg_erase_chip = 1'b0;
        i_prg_erase_block = 1'b0;
    endtask
    task automatic give_verdict();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    initial begin
        repeat (4) @(negedge i_sys_clk);
        i_rst = 1'b0;
        repeat (3) @(negedge i_sys_clk);
        `CHK("settings", {1'b1, 3'h0, 16'h0010, 10'b0101111110},
            {o_config_valid, o_settings})
        i_software_watchdog_enable_bit = 1'b1;
        repeat (2) @(negedge i_sys_clk);
        `CHK("sw run", 1'b1, o_settings.watchdog_run)
        i_software_watchdog_enable_bit = 1'b0;
        rdchk(0, 22'h3ffffe, 8'h3c);
        acc(0, 1'b0, 1'b1, ADDR_WDT, 8'hff);
        `CHK("nv write", 12'h81f,
            {o_nv_wr, o_nv_index, o_nv_wdata})
        rdchk(0, ADDR_WDT, 8'h1f);
        acc(0, 1'b0, 1'b1, ADDR_CP, 8'hff);
        rdchk(0, ADDR_CP, 8'h0e);
        `CHK("force run", 17'h10001, {o_settings.watchdog_ratio,
            o_settings.watchdog_run})
        rdchk(0, 22'h001000, 8'h5a);
        rdchk(0, 22'h004000, 8'h00);
        i_tbl_pc = 22'h004100;
        rdchk(0, 22'h004000, 8'h5a);
        rdchk(1, 22'h001000, 8'h00);
        `CHK("denied", 1'b1, o_prg_denied)
        rdchk(1, 22'h004000, 8'h5a);
        i_prg_eeprom = 1'b1;
        rdchk(1, 22'h000010, 8'h00);
        acc(1, 1'b0, 1'b1, 22'h000010, 8'h11);
        `CHK("ee wr", 2'b10, {o_prg_denied, o_ee_wr})
        i_prg_eeprom = 1'b0;
        acc(0, 1'b0, 1'b1, 22'h002100, 8'h77);
        `CHK("blocked", 2'b10, {o_tbl_wr_blocked, o_pm_wr})
        acc(0, 1'b0, 1'b1, 22'h006000, 8'h77);
        `CHK("pm wr", 32'h40600077, {o_tbl_wr_blocked, o_pm_wr, o_mem_addr,
            o_mem_wdata})
        erase(0);
        `CHK("erase", 4'h8, {o_erase_block, o_erase_sel})
        rdchk(0, ADDR_CP, 8'h0f);
        i_stack_fault = 1'b1;
        @(negedge i_sys_clk);
        i_stack_fault = 1'b0;
        `CHK("stack", 1'b1, o_stack_fault_reset)
        i_shared_reset_input_pin_n = 1'b0;
        repeat (4) @(negedge i_sys_clk);
        `CHK("pin", 2'b10,
            {o_master_reset_input, o_shared_pin_data})
        erase(1);
        `CHK("chip erase", 1'b1, o_erase_chip)
        rdchk(0, ADDR_CPB, 8'hc0);
        give_verdict();
    end
endmodule
